// [tb_vectored_interrupt_controller.sv]
`timescale 1ns/10ps
`include "vru_consts.vh"
module tb_vectored_interrupt_controller;
   reg         clk = 0;
   reg         rstn = 0;
   reg  [31:0] irq = 0;
   reg  [31:0] p0 = 0;
   reg  [31:0] p2 = 32'hFFFFFFFF;
   reg         cyc = 0;
   reg         stb = 0;
   reg         we = 0;
   reg  [8:0]  adr = 0;
   reg  [31:0] dat = 0;
   reg  [31:0] rq;
   wire [31:0] rdat;
   wire        ack, fq, nq;
   wire [1:0]  mode;
   integer     miscompares = 0, num_checks = 0, cycles = 0;
   vru_vectored_request_unit uut (.i_clock(clk), .i_rstn(rstn), .i_irq(irq), .i_port0(p0), .i_port2(p2),
      .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(dat),
      .o_wb_dat(rdat), .o_wb_ack(ack), .o_fast_interrupt_request(fq), .o_normal_interrupt(nq));
   vru_core_model u_core (.i_clock(clk), .i_fast(fq), .i_normal(nq), .o_mode(mode));
   initial begin
      forever #5 clk = ~clk;
   end
   // hang guard
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         miscompares = miscompares + 1;
         tally_and_finish;
      end
   end
   task check(input [31:0] seen, input [31:0] exp);
      begin
         num_checks = num_checks + 1;
         if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("BAD %0t got %h want %h", $time, seen, exp);
         end
      end
   endtask
   // classic single cycle, held until ack
   task wb(input w, input [8:0] a, input [31:0] d);
      begin
         @(posedge clk);
         cyc <= 1'b1;
         stb <= 1'b1;
         we  <= w;
         adr <= a;
         dat <= d;
         // look at ack where it is settled, then release after the edge that samples it
         do @(negedge clk); while (ack !== 1'b1);
         rq = rdat;
         @(posedge clk);
         cyc <= 1'b0;
         stb <= 1'b0;
      end
   endtask
   task rc(input [8:0] a, input [31:0] e);
      begin
         wb(1'b0, a, 32'h00000000);
         check(rq, e);
      end
   endtask
   task settle;
      repeat (8) @(posedge clk);
   endtask
   task t_reset;
      begin
         rc(`VRU_ADDR_ENABLE, 32'h00000000);
         rc(`VRU_ADDR_CLASS, 32'h00000000);
         rc(`VRU_ADDR_PRIO_BASE + 8'h7C, 32'h0000000F);
         rc(9'h03C, 32'h00000000);
         check({fq, nq}, 2'h0);
      end
   endtask
   task t_fast;
      begin
         wb(1'b1, `VRU_ADDR_ENABLE, 32'h00000028);
         wb(1'b1, `VRU_ADDR_CLASS, 32'h00000028);
         wb(1'b1, `VRU_ADDR_DEF_ADDR, 32'h0000D000);
         irq <= 32'h00000028;
         settle;
         check({fq, nq}, 2'h2);
         rc(`VRU_ADDR_FAST_STATUS, 32'h00000028);
         rc(`VRU_ADDR_VECT_ADDR, 32'h0000D000);
         check(mode, 2'h2);
         irq <= 32'h00000008;
         settle;
         check(fq, 1'b1);
         rc(`VRU_ADDR_FAST_STATUS, 32'h00000008);
         irq <= 32'h00000000;
         settle;
         check(fq, 1'b0);
      end
   endtask
   task t_prio;
      begin
         wb(1'b1, `VRU_ADDR_ENABLE, 32'h00000210);
         wb(1'b1, `VRU_ADDR_CLASS, 32'h00000000);
         wb(1'b1, `VRU_ADDR_PRIO_BASE + 8'h10, 32'h00000003);
         wb(1'b1, `VRU_ADDR_PRIO_BASE + 8'h24, 32'h00000003);
         wb(1'b1, {1'b1, `VRU_ADDR_HAND_BASE + 8'h10}, 32'h00001400);
         wb(1'b1, {1'b1, `VRU_ADDR_HAND_BASE + 8'h24}, 32'h00001900);
         irq <= 32'h00000210;
         settle;
         check(nq, 1'b1);
         check(mode, 2'h1);
         rc(`VRU_ADDR_VECT_ADDR, 32'h00001400);
         wb(1'b1, `VRU_ADDR_PRIO_BASE + 8'h24, 32'h00000001);
         rc(`VRU_ADDR_VECT_ADDR, 32'h00001900);
         wb(1'b1, `VRU_ADDR_CLASS, 32'h00000200);
         settle;
         rc(`VRU_ADDR_VECT_ADDR, 32'h0000D000);
         check({fq, nq}, 2'h3);
         rc(`VRU_ADDR_NORM_STATUS, 32'h00000010);
         irq <= 32'h00000000;
         settle;
      end
   endtask
   task t_edge;
      begin
         wb(1'b1, `VRU_ADDR_ENABLE, 32'h00020000);
         wb(1'b1, `VRU_ADDR_EXT_RISE0, 32'h00000004);
         wb(1'b1, `VRU_ADDR_EXT_FALL2, 32'h00000080);
         p0 <= 32'h00000004;
         settle;
         check(nq, 1'b1);
         rc(`VRU_ADDR_EXT_STAT0, 32'h00000004);
         wb(1'b1, `VRU_ADDR_EXT_STAT0, 32'h00000004);
         settle;
         check(nq, 1'b0);
         p2 <= 32'hFFFFFF7F;
         settle;
         rc(`VRU_ADDR_EXT_STAT2, 32'h00000080);
         rc(`VRU_ADDR_RAW_STATUS, 32'h00020000);
      end
   endtask
   task tally_and_finish;
      begin
         if (miscompares == 0 && num_checks > 0)
            $display("TB: PASS");
         else
            $display("TB: FAIL");
         $finish;
      end
   endtask
   initial begin
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      repeat (3) @(posedge clk);
      t_reset;
      t_fast;
      t_prio;
      t_edge;
      tally_and_finish;
   end
endmodule // tb_vectored_interrupt_controller

// [vru_consts.vh]
`ifndef VRU_CONSTS_VH
`define VRU_CONSTS_VH
// register byte offsets
`define VRU_ADDR_RAW_STATUS  8'h00
`define VRU_ADDR_FAST_STATUS 8'h04
`define VRU_ADDR_NORM_STATUS 8'h08
`define VRU_ADDR_ENABLE      8'h0C
`define VRU_ADDR_CLASS       8'h10
`define VRU_ADDR_VECT_ADDR   8'h14
`define VRU_ADDR_DEF_ADDR    8'h18
`define VRU_ADDR_EXT_RISE0   8'h1C
`define VRU_ADDR_EXT_RISE2   8'h20
`define VRU_ADDR_EXT_FALL0   8'h24
`define VRU_ADDR_EXT_FALL2   8'h28
`define VRU_ADDR_EXT_STAT0   8'h2C
`define VRU_ADDR_EXT_STAT2   8'h30
`define VRU_ADDR_PRIO_BASE   8'h80
`define VRU_ADDR_HAND_BASE   8'h00
// address window bits: bit 8 selects handler table
`define VRU_SEL_HAND_BIT     8
// field layout
`define VRU_PRIO_W           4
`define VRU_CHAN_W           5
`define VRU_NCHAN            32
// external_interrupt_three input channel
`define VRU_EXT3_CHAN        17
// reset values
`define VRU_RST_ENABLE       32'h00000000
`define VRU_RST_CLASS        32'h00000000
`define VRU_RST_PRIO         4'hF
`define VRU_RST_ADDR         32'h00000000
`define VRU_UNMAPPED_DATA    32'h00000000
`endif

// [vru_core_model.sv]
`timescale 1ns/10ps
module vru_core_model (
   input  wire       i_clock,  // clock
   input  wire       i_fast,   // fast request in
   input  wire       i_normal, // normal request in
   output reg  [1:0] o_mode    // 2 fast, 1 normal, 0 thread
);
   // fast entry wins over normal entry
   always @(posedge i_clock) begin
      o_mode <= i_fast ? 2'h2 : {1'b0, i_normal};
   end
endmodule // vru_core_model

// [vru_props.sv]
`timescale 1ns/10ps
module vru_props (
   input wire        i_clock,                  // clock
   input wire        i_rstn,                   // reset
   input wire [31:0] i_irq,                    // requests
   input wire [31:0] i_port0,                  // port 0
   input wire [31:0] i_port2,                  // port 2
   input wire        i_wb_cyc,                 // cycle
   input wire        i_wb_stb,                 // strobe
   input wire        i_wb_we,                  // write
   input wire [31:0] o_wb_dat,                 // read data
   input wire        o_wb_ack,                 // ack
   input wire        o_fast_interrupt_request, // fast out
   input wire        o_normal_interrupt        // normal out
);
   reg [3:0] quiet; // edges since last input change or access
   reg [3:0] zero;  // edges with no request
   reg       pseen; // a port pin has moved
   wire      fq = o_fast_interrupt_request;
   wire      nq = o_normal_interrupt;
   // count quiet stretches
   always @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         quiet <= 4'h0;
         zero  <= 4'h0;
         pseen <= 1'b0;
      end else begin
         quiet <= (i_irq != $past(i_irq) || i_wb_cyc || i_port0 != $past(i_port0)
                   || i_port2 != $past(i_port2)) ? 4'h0 : quiet + (quiet != 4'hF);
         zero  <= (|i_irq) ? 4'h0 : zero + (zero != 4'hF);
         pseen <= pseen || i_port0 != $past(i_port0) || i_port2 != $past(i_port2);
      end
   end
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_rstn);
   a_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack held");
   a_ack_latency: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack) else $error("late ack");
   a_ack_cause: assert property (o_wb_ack |-> $past(i_wb_cyc && i_wb_stb)) else $error("stray ack");
   a_dat_idle: assert property (!o_wb_ack |-> o_wb_dat == 32'h00000000) else $error("data off ack");
   a_out_steady: assert property (quiet >= 8 |-> $stable(fq) && $stable(nq)) else $error("output moved");
   a_idle_low: assert property (zero >= 8 && !pseen |-> !fq && !nq) else $error("output w/o request");
   a_fast_cause: assert property ($rose(fq) |-> quiet < 8) else $error("fast rose alone");
   a_norm_cause: assert property ($changed(nq) |-> quiet < 8) else $error("normal moved alone");
   c_fast: cover property ($rose(fq));
   c_norm: cover property ($rose(nq));
   c_write: cover property (o_wb_ack && $past(i_wb_we));
endmodule // vru_props
bind vru_vectored_request_unit vru_props u_props (.i_clock, .i_rstn, .i_irq, .i_port0, .i_port2, .i_wb_cyc,
   .i_wb_stb, .i_wb_we, .o_wb_dat, .o_wb_ack, .o_fast_interrupt_request, .o_normal_interrupt);

// [vru_vectored_request_unit.v]
`timescale 1ns/10ps
`include "vru_consts.vh"
// What this block does
// (R1) accepts 32 request inputs, each programmable fast or vectored class
// (R2) fast requests always beat any vectored request regardless of priority
// (R3) fast output is the OR of all active fast requests
// (R4) readable word shows which fast sources are requesting now
// (R5) every non-fast input is vectored with its own programmable priority
// (R6) equal priorities resolve to the lowest-numbered channel
// (R7) normal output is the OR of all active vectored requests
// (R8) readable register gives handler address of the selected vectored request
// (R9) class and priority writable at run time, arbitration follows at once
// (R10) each peripheral presents one merged request line
// (R11) rising, falling or both edges on 64 port pins merge into channel 17
// (R12) inputs are levels; outputs stay high while any enabled request stays
module vru_vectored_request_unit (
   input  wire        i_clock,     // system clock, 100 MHz
   input  wire        i_rstn,      // async reset, active low
   input  wire [31:0] i_irq,       // peripheral request levels
   input  wire [31:0] i_port0,     // port 0 pin levels
   input  wire [31:0] i_port2,     // port 2 pin levels
   input  wire        i_wb_cyc,    // wishbone cycle
   input  wire        i_wb_stb,    // wishbone strobe
   input  wire        i_wb_we,     // wishbone write enable
   input  wire [8:0]  i_wb_adr,    // wishbone byte address
   input  wire [3:0]  i_wb_sel,    // wishbone byte selects
   input  wire [31:0] i_wb_dat,    // wishbone write data
   output reg  [31:0] o_wb_dat,    // wishbone read data
   output reg         o_wb_ack,    // wishbone acknowledge
   output reg         o_fast_interrupt_request, // to core fast input
   output reg         o_normal_interrupt       // to core normal input
);
   // reset release synchroniser
   reg        rst_meta;
   reg        rst_n;
   always @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // three-stage pin synchronisers
   reg [31:0] irq_s1, irq_s2, irq_s3, irq_lvl;
   reg [31:0] p0_s1, p0_s2, p0_s3, p0_lvl;
   reg [31:0] p2_s1, p2_s2, p2_s3, p2_lvl;
   always @(posedge i_clock or negedge rst_n) begin
      if (!rst_n) begin
         irq_s1  <= 32'h00000000;
         irq_s2  <= 32'h00000000;
         irq_s3  <= 32'h00000000;
         irq_lvl <= 32'h00000000;
         p0_s1   <= 32'h00000000;
         p0_s2   <= 32'h00000000;
         p0_s3   <= 32'h00000000;
         p0_lvl  <= 32'h00000000;
         p2_s1   <= 32'h00000000;
         p2_s2   <= 32'h00000000;
         p2_s3   <= 32'h00000000;
         p2_lvl  <= 32'h00000000;
      end else begin
         // shift chains, stage one read only by stage two
         irq_s1 <= i_irq;
         irq_s2 <= irq_s1;
         irq_s3 <= irq_s2;
         p0_s1  <= i_port0;
         p0_s2  <= p0_s1;
         p0_s3  <= p0_s2;
         p2_s1  <= i_port2;
         p2_s2  <= p2_s1;
         p2_s3  <= p2_s2;
         // a bit changes only when stages two and three agree
         irq_lvl <= (irq_s2 & irq_s3) | (irq_lvl & (irq_s2 | irq_s3)); // R12
         p0_lvl  <= (p0_s2 & p0_s3) | (p0_lvl & (p0_s2 | p0_s3));
         p2_lvl  <= (p2_s2 & p2_s3) | (p2_lvl & (p2_s2 | p2_s3));
      end
   end

   // software registers
   reg [31:0] enable;
   reg [31:0] fast_class;
   reg [31:0] def_addr;
   reg [31:0] rise0, rise2, fall0, fall2;
   reg [31:0] ext0, ext2;
   reg [`VRU_PRIO_W-1:0] prio [0:`VRU_NCHAN-1];
   reg [31:0] hand [0:`VRU_NCHAN-1];
   reg [31:0] p0_prev, p2_prev;

   // bus decode
   wire        req      = i_wb_cyc & i_wb_stb & ~o_wb_ack;
   // a write lands at the edge that samples ack high, address still held
   wire        wr       = i_wb_cyc & i_wb_stb & i_wb_we & o_wb_ack;
   wire        is_hand  = i_wb_adr[`VRU_SEL_HAND_BIT];
   wire        is_prio  = ~is_hand & (i_wb_adr[7:0] >= `VRU_ADDR_PRIO_BASE);
   wire [4:0]  widx     = i_wb_adr[6:2];

   // byte-lane merge
   function [31:0] vru_merge;
      input [31:0] old_v;
      input [31:0] new_v;
      input [3:0]  sel;
      integer k;
      begin
         for (k = 0; k < 4; k = k + 1)
            vru_merge[k*8 +: 8] = sel[k] ? new_v[k*8 +: 8] : old_v[k*8 +: 8];
      end
   endfunction

   // edge detection on both ports
   wire [31:0] ev0 = (p0_lvl & ~p0_prev & rise0) | (~p0_lvl & p0_prev & fall0); // R11
   wire [31:0] ev2 = (p2_lvl & ~p2_prev & rise2) | (~p2_lvl & p2_prev & fall2); // R11
   wire [31:0] clr0 = (wr && !is_hand && i_wb_adr[7:0] == `VRU_ADDR_EXT_STAT0) ?
                      vru_merge(32'h00000000, i_wb_dat, i_wb_sel) : 32'h00000000;
   wire [31:0] clr2 = (wr && !is_hand && i_wb_adr[7:0] == `VRU_ADDR_EXT_STAT2) ?
                      vru_merge(32'h00000000, i_wb_dat, i_wb_sel) : 32'h00000000;

   // effective raw requests with merged edge line
   wire        ext3_req = (|ext0) | (|ext2);                           // R11
   wire [31:0] raw      = irq_lvl | ({31'h00000000, ext3_req} << `VRU_EXT3_CHAN); // R10
   wire [31:0] active   = raw & enable;
   wire [31:0] fast_act = active & fast_class;                         // R1
   wire [31:0] norm_act = active & ~fast_class;                        // R5

   // priority arbiter: lower level wins, ties to lowest channel
   reg [`VRU_PRIO_W-1:0] best_p;
   reg [`VRU_CHAN_W-1:0] best_c;
   reg                   best_v;
   integer j;
   always @* begin
      best_p = `VRU_RST_PRIO;
      best_c = 5'h00;
      best_v = 1'b0;
      for (j = 0; j < `VRU_NCHAN; j = j + 1) begin
         // strict less-than keeps the earlier channel on a tie
         if (norm_act[j] && (!best_v || prio[j] < best_p)) begin // R6
            best_p = prio[j];
            best_c = j[`VRU_CHAN_W-1:0];
            best_v = 1'b1;
         end
      end
   end

   // register writes, edge capture and outputs
   integer i;
   always @(posedge i_clock or negedge rst_n) begin
      if (!rst_n) begin
         enable     <= `VRU_RST_ENABLE;
         fast_class <= `VRU_RST_CLASS;
         def_addr   <= `VRU_RST_ADDR;
         rise0      <= 32'h00000000;
         rise2      <= 32'h00000000;
         fall0      <= 32'h00000000;
         fall2      <= 32'h00000000;
         ext0       <= 32'h00000000;
         ext2       <= 32'h00000000;
         p0_prev    <= 32'h00000000;
         p2_prev    <= 32'h00000000;
         for (i = 0; i < `VRU_NCHAN; i = i + 1) begin
            prio[i] <= `VRU_RST_PRIO;
            hand[i] <= `VRU_RST_ADDR;
         end
         o_fast_interrupt_request <= 1'b0;
         o_normal_interrupt       <= 1'b0;
      end else begin
         p0_prev <= p0_lvl;
         p2_prev <= p2_lvl;
         // write-one-to-clear, new edge wins
         ext0 <= (ext0 & ~clr0) | ev0;                                 // R11
         ext2 <= (ext2 & ~clr2) | ev2;                                 // R11
         if (wr && is_hand) begin
            hand[widx] <= vru_merge(hand[widx], i_wb_dat, i_wb_sel);
         end else if (wr && is_prio) begin
            if (i_wb_sel[0])
               prio[widx] <= i_wb_dat[`VRU_PRIO_W-1:0];                // R9
         end else if (wr) begin
            case (i_wb_adr[7:0])
               `VRU_ADDR_ENABLE:   enable     <= vru_merge(enable, i_wb_dat, i_wb_sel);
               `VRU_ADDR_CLASS:    fast_class <= vru_merge(fast_class, i_wb_dat, i_wb_sel); // R9
               `VRU_ADDR_DEF_ADDR: def_addr   <= vru_merge(def_addr, i_wb_dat, i_wb_sel);
               `VRU_ADDR_EXT_RISE0: rise0 <= vru_merge(rise0, i_wb_dat, i_wb_sel);
               `VRU_ADDR_EXT_RISE2: rise2 <= vru_merge(rise2, i_wb_dat, i_wb_sel);
               `VRU_ADDR_EXT_FALL0: fall0 <= vru_merge(fall0, i_wb_dat, i_wb_sel);
               `VRU_ADDR_EXT_FALL2: fall2 <= vru_merge(fall2, i_wb_dat, i_wb_sel);
               default: ;
            endcase
         end
         o_fast_interrupt_request <= |fast_act;                        // R3
         o_normal_interrupt       <= |norm_act;                        // R7
      end
   end

   // read mux
   reg [31:0] rdata;
   always @* begin
      rdata = `VRU_UNMAPPED_DATA;
      if (is_hand) begin
         rdata = hand[widx];
      end else if (is_prio) begin
         rdata = {28'h0000000, prio[widx]};
      end else begin
         case (i_wb_adr[7:0])
            `VRU_ADDR_RAW_STATUS:  rdata = raw;
            `VRU_ADDR_FAST_STATUS: rdata = fast_act;                   // R4
            `VRU_ADDR_NORM_STATUS: rdata = norm_act;
            `VRU_ADDR_ENABLE:      rdata = enable;
            `VRU_ADDR_CLASS:       rdata = fast_class;
            // fast pending masks any vectored answer
            `VRU_ADDR_VECT_ADDR:   rdata = (best_v && !(|fast_act)) ? hand[best_c] : def_addr; // R8 R2
            `VRU_ADDR_DEF_ADDR:    rdata = def_addr;
            `VRU_ADDR_EXT_RISE0:   rdata = rise0;
            `VRU_ADDR_EXT_RISE2:   rdata = rise2;
            `VRU_ADDR_EXT_FALL0:   rdata = fall0;
            `VRU_ADDR_EXT_FALL2:   rdata = fall2;
            `VRU_ADDR_EXT_STAT0:   rdata = ext0;
            `VRU_ADDR_EXT_STAT2:   rdata = ext2;
            default:               rdata = `VRU_UNMAPPED_DATA;
         endcase
      end
   end

   // one-wait-state acknowledge
   always @(posedge i_clock or negedge rst_n) begin
      if (!rst_n) begin
         o_wb_ack <= 1'b0;
         o_wb_dat <= 32'h00000000;
      end else begin
         o_wb_ack <= req;
         o_wb_dat <= req ? rdata : 32'h00000000;
      end
   end
endmodule // vru_vectored_request_unit
